/* rtl/dhrt_target.sv */
// Burst-read target of the multiplexed address/data bus.
module dhrt_target #(
  parameter int unsigned MEM_AW = dhrt_pkg::MEM_AW,
  parameter logic [31:0] BASE_ADDR = dhrt_pkg::BASE_ADDR_RST
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link side pins.
  // link pins.
  input wire logic bus_request,
  input wire logic bus_next,
  input wire logic [31:0] bus_ad_in,
  output logic [31:0] bus_ad_out,
  output logic bus_ad_oe,
  output logic target_handshake_out,
  output logic target_handshake_oe,
  // User side memory fill port.
  input wire logic fill_en,
  input wire logic [MEM_AW-1:0] fill_addr,
  input wire logic [31:0] fill_data,
  // Status.
  output logic busy
);

  localparam int unsigned CW = 4;
  localparam logic [CW-1:0] ACK_HI_CNT =
    CW'(dhrt_pkg::ACK_HIGH_MIN_T - 1);
  localparam logic [CW-1:0] FLOAT_CNT = CW'(dhrt_pkg::FLOAT_MAX_T);
  localparam logic [CW-1:0] SETUP_CNT =
    CW'(dhrt_pkg::DATA_SETUP_MIN_T);
  // After next the new word reaches the pins two edges late (memory read
  // register, then pin register), so the resettle count is one longer.
  localparam logic [CW-1:0] RESETTLE_CNT =
    CW'(dhrt_pkg::DATA_SETUP_MIN_T + 1);

  dhrt_pkg::dhrt_state_e state_q;
  dhrt_pkg::dhrt_state_e state_d;
  logic [1:0] req_sync_q;
  logic [1:0] next_sync_q;
  logic req_prev_q;
  logic next_prev_q;
  logic [31:0] ad_sync1_q;
  logic [31:0] ad_sync2_q;
  logic [MEM_AW-1:0] rd_addr_q;
  logic [CW-1:0] cnt_q;
  logic [31:0] rd_data;
  logic req_s;
  logic next_s;
  logic req_rise;
  logic next_rise;
  logic hit;

  // Returns true when a bus address falls in our window.
  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic [31:0] base);
    logic [31:0] off;
    off = a - base;
    addr_hit = (off >> MEM_AW) == 32'h0000_0000;
  endfunction : addr_hit

  // ==========================================================================
  // Input synchronisers.
  // sync inputs.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req_sync_q <= 2'h0;
      next_sync_q <= 2'h0;
      req_prev_q <= 1'b0;
      next_prev_q <= 1'b0;
    end else begin
      req_sync_q <= {req_sync_q[0], bus_request};
      next_sync_q <= {next_sync_q[0], bus_next};
      req_prev_q <= req_sync_q[1];
      next_prev_q <= next_sync_q[1];
    end
  end

  // Address lines pass two stages; the master settled them before request.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ad_sync1_q <= 32'h0000_0000;
      ad_sync2_q <= 32'h0000_0000;
    end else begin
      ad_sync1_q <= bus_ad_in;
      ad_sync2_q <= ad_sync1_q;
    end
  end

  assign req_s = req_sync_q[1];
  assign next_s = next_sync_q[1];
  assign req_rise = req_s & ~req_prev_q;
  assign next_rise = next_s & ~next_prev_q;
  assign hit = addr_hit(ad_sync2_q, BASE_ADDR);

  // ==========================================================================
  // Handshake state machine.
  always_comb begin
    state_d = state_q;
    case (state_q)
      dhrt_pkg::DHRT_IDLE: begin
        if (req_rise && hit) begin
          state_d = dhrt_pkg::DHRT_ACKHI;
        end
      end
      dhrt_pkg::DHRT_ACKHI: begin
        if (cnt_q == ACK_HI_CNT) begin
          state_d = dhrt_pkg::DHRT_DRIVE;
        end
      end
      dhrt_pkg::DHRT_DRIVE: begin
        if (cnt_q == SETUP_CNT) begin
          state_d = dhrt_pkg::DHRT_VALID;
        end
      end
      dhrt_pkg::DHRT_VALID: begin
        if (next_rise) begin
          state_d = dhrt_pkg::DHRT_NEXT;
        end
      end
      dhrt_pkg::DHRT_NEXT: begin
        if (cnt_q == RESETTLE_CNT) begin
          state_d = dhrt_pkg::DHRT_VALID;
        end
      end
      dhrt_pkg::DHRT_DONE: begin
        if (!req_s) begin
          state_d = dhrt_pkg::DHRT_IDLE;
        end
      end
      default: begin
        state_d = dhrt_pkg::DHRT_IDLE;
      end
    endcase
    if (!req_s) begin
      state_d = dhrt_pkg::DHRT_IDLE;
    end
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= dhrt_pkg::DHRT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Phase counter restarts on every state change.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_d != state_q) begin
      cnt_q <= '0;
    end else if (cnt_q != '1) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // ==========================================================================
  // Read address.
  // step address.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_addr_q <= '0;
    end else if (state_q == dhrt_pkg::DHRT_IDLE && req_rise && hit) begin
      rd_addr_q <= MEM_AW'(ad_sync2_q - BASE_ADDR);
    end else if (state_q == dhrt_pkg::DHRT_VALID && next_rise) begin
      rd_addr_q <= rd_addr_q + MEM_AW'(1);
    end
  end

  dhrt_mem #(
    .AW(MEM_AW),
    .DW(dhrt_pkg::DATA_W)
  ) u_mem (
    .sys_clk(sys_clk),
    .wr_en(fill_en),
    .wr_addr(fill_addr),
    .wr_data(fill_data),
    .rd_addr(rd_addr_q),
    .rd_data_q(rd_data)
  );

  // ==========================================================================
  // Pin drivers, all from flip-flops.
  // float then drive.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_ad_oe <= 1'b0;
      bus_ad_out <= 32'h0000_0000;
    end else begin
      bus_ad_oe <= (state_d == dhrt_pkg::DHRT_DRIVE ||
                    state_d == dhrt_pkg::DHRT_VALID ||
                    state_d == dhrt_pkg::DHRT_NEXT) &&
                   !(state_q == dhrt_pkg::DHRT_ACKHI &&
                     cnt_q < FLOAT_CNT);
      bus_ad_out <= rd_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      target_handshake_oe <= 1'b0;
      target_handshake_out <= 1'b0;
    end else begin
      target_handshake_oe <= state_d != dhrt_pkg::DHRT_IDLE;
      target_handshake_out <= state_d != dhrt_pkg::DHRT_IDLE &&
                              state_d != dhrt_pkg::DHRT_VALID;
    end
  end

  assign busy = state_q != dhrt_pkg::DHRT_IDLE;

endmodule : dhrt_target

/* rtl/dhrt_pkg.sv */
// Package with constants and types for the burst-read target block.
// What this block does
// - Request, next, target_handshake lines and a 32-bit two-way data path.
// - On request rise, capture shared lines and compare with our range.
// - On a miss, do nothing and drive neither target_handshake nor data.
// - When selected, drive target_handshake high for at least 6 periods first.
// - Fetch the start word; drive it only after a one-period bus float.
// - Drop target_handshake after data has been stable at least 2 periods.
// - On next high, raise target_handshake at once and fetch the next word.
// - Lower target_handshake again no sooner than 1 period after next.
// - Burst runs until request drops; then stop driving the shared lines.
package dhrt_pkg;

  // ==========================================================================
  // Timing.
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned ADDR_SETUP_PS = 20000;
  localparam int unsigned ACK_HIGH_MIN_T = 6;
  localparam int unsigned DATA_SETUP_MIN_T = 2;
  localparam int unsigned ACK_AFTER_NEXT_MIN_T = 1;
  localparam int unsigned FLOAT_MAX_T = 1;
  // Address setup expressed in clocks, rounded up; the master model waits this long before request.
  localparam int unsigned ADDR_SETUP_CYC =
    (ADDR_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================================
  // Sizes and defaults.
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MEM_AW = 8;
  localparam logic [31:0] BASE_ADDR_RST = 32'h0000_1000;

  // ==========================================================================
  // Target states, Gray coded along the burst path.
  typedef enum logic [2:0] {
    DHRT_IDLE  = 3'b000,
    DHRT_ACKHI = 3'b001,
    DHRT_DRIVE = 3'b011,
    DHRT_VALID = 3'b010,
    DHRT_NEXT  = 3'b110,
    DHRT_DONE  = 3'b111
  } dhrt_state_e;

endpackage : dhrt_pkg

/* rtl/dhrt_mem.sv */
// Word memory holding the data the target returns, registered read port.
module dhrt_mem #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 32
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_q
);

  logic [DW-1:0] mem_q [2**AW];

  // Write port from the user side.
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read data come out of a register, one cycle after the address.
  always_ff @(posedge sys_clk) begin
    rd_data_q <= mem_q[rd_addr];
  end

endmodule : dhrt_mem

/* test/dhrt_target_monitor.sv */
// Checker of the target's link timing.
module dhrt_target_monitor (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic bus_request,
  input wire logic bus_next,
  input wire logic [31:0] bus_ad_in,
  input wire logic [31:0] bus_ad_out,
  input wire logic bus_ad_oe,
  input wire logic target_handshake_out,
  input wire logic target_handshake_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Address window hit, as the target should decode it.
  logic hit;
  assign hit = (bus_ad_in - dhrt_pkg::BASE_ADDR_RST) < 32'h0000_0100;
  property p_hit; $rose(bus_request) && hit |-> ##[2:6] target_handshake_oe;
  endproperty
  a_hit: assert property (p_hit) else $error("hit not answered");
  property p_miss; $rose(bus_request) && !hit |-> !target_handshake_oe [*8];
  endproperty
  a_miss: assert property (p_miss) else $error("miss answered");
  property p_ackhi; $rose(target_handshake_oe) |-> target_handshake_out [*6];
  endproperty
  a_ackhi: assert property (p_ackhi) else $error("short high");
  property p_float; $rose(bus_ad_oe) |-> $past(target_handshake_oe);
  endproperty
  a_float: assert property (p_float) else $error("no float");
  property p_setup; $fell(target_handshake_out) && target_handshake_oe |->
    bus_ad_oe && $stable(bus_ad_out) && bus_ad_out == $past(bus_ad_out, 2);
  endproperty
  a_setup: assert property (p_setup) else $error("data unsettled");
  property p_next; $rose(bus_next) && bus_request |->
    ##[1:4] target_handshake_out; endproperty
  a_next: assert property (p_next) else $error("next unanswered");
  property p_nolow; $rose(bus_next) |-> !$fell(target_handshake_out) [*2];
  endproperty
  a_nolow: assert property (p_nolow) else $error("low too soon");
  property p_resettle; $rose(target_handshake_out) &&
    $past(target_handshake_oe) |-> target_handshake_out [*4]; endproperty
  a_resettle: assert property (p_resettle) else $error("unsettled");
  property p_rel; !bus_request [*4] |-> !bus_ad_oe && !target_handshake_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("not released");
endmodule : dhrt_target_monitor
bind dhrt_target dhrt_target_monitor mon_u (.sys_clk, .sys_rst,
  .bus_request, .bus_next, .bus_ad_in, .bus_ad_out, .bus_ad_oe,
  .target_handshake_out, .target_handshake_oe);

/* test/dhrt_master_model.sv */
// Bus master model that runs read bursts against the target.
module dhrt_master_model (
  input wire logic sys_clk,
  input wire logic ack,
  input wire logic [31:0] ad_w,
  output logic req,
  output logic nxt,
  output logic [31:0] ad_q,
  output logic ad_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] got [8];
  int hung;
  // Idle link at time zero.
  initial begin
    req = 0;
    nxt = 0;
    ad_q = '0;
    ad_oe = 0;
    hung = 0;
  end
  // Waits a bounded time for a handshake level.
  task automatic w(input logic v);
    int t;
    t = 0;
    while (ack !== v && t < 40) begin
      @(posedge sys_clk);
      t++;
    end
    if (ack !== v) hung++;
  endtask : w
  // Runs one burst of n words with gap idle cycles per word.
  task automatic run(input logic [31:0] a, input int n, input int gap);
    @(posedge sys_clk);
    ad_q <= a;
    ad_oe <= 1;
    repeat (dhrt_pkg::ADDR_SETUP_CYC) @(posedge sys_clk);
    req <= 1;
    w(1);
    ad_oe <= 0;
    for (int i = 0; i < n; i++) begin
      w(0);
      got[i] = ad_w;
      repeat (gap) @(posedge sys_clk);
      if (i < n - 1) begin
        nxt <= 1;
        w(1);
        nxt <= 0;
      end
    end
    req <= 0;
    repeat (6) @(posedge sys_clk);
  endtask : run
endmodule : dhrt_master_model

/* test/dma_handshake_read_target_tb.sv */
// Testbench running read bursts through the burst-read target.
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  fails++; $display("unexpected %s exp %h got %h", n, e, a); end end
module dma_handshake_read_target_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, sys_rst, fill_en, busy, ad_oe, ack_out, ack_oe, m_oe;
  logic req, nxt, ack_w;
  logic [7:0] fill_addr;
  logic [31:0] fill_data, ad_out, m_ad, ad_last, ad_w;
  logic [31:0] base = dhrt_pkg::BASE_ADDR_RST;
  int fails, samples_checked, seen;
  // Shared lines resolve to the enabled driver, else a changing pattern (data) or low (handshake).
  assign ad_w = ad_oe ? ad_out : (m_oe ? m_ad : ~ad_last);
  assign ack_w = ack_oe ? ack_out : 1'b0;
  // Tracks the last line value and counts handshake drive cycles.
  always @(posedge sys_clk) begin
    ad_last <= sys_rst ? 32'h0000_0000 : ad_w;
    if (ack_oe === 1'b1) seen <= seen + 1;
  end
  dhrt_target dut_u (.sys_clk, .sys_rst, .bus_request(req), .bus_next(nxt),
    .bus_ad_in(ad_w), .bus_ad_out(ad_out), .bus_ad_oe(ad_oe),
    .target_handshake_out(ack_out), .target_handshake_oe(ack_oe),
    .fill_en, .fill_addr, .fill_data, .busy);
  dhrt_master_model m_u (.sys_clk, .ack(ack_w), .ad_w, .req, .nxt,
    .ad_q(m_ad), .ad_oe(m_oe));
  // Word stored at each memory index.
  function automatic logic [31:0] fv(input int i);
    return 32'h5A5A_0000 ^ (i * 32'h0001_0203);
  endfunction : fv
  task automatic burst(input logic [31:0] a, input int n, input int gap);
    int h0;
    h0 = m_u.hung;
    m_u.run(a, n, gap);
    for (int k = 0; k < n; k++)
      `CHK("word", fv((a - base + k) % 256), m_u.got[k])
    `CHK("hang", h0, m_u.hung)
    `CHK("release", 3'b000, {ad_oe, ack_oe, busy})
  endtask : burst
  task automatic t_first();
    burst(base, 4, 0);
    $display("test first burst done");
  endtask : t_first
  task automatic t_wrap();
    burst(base + 254, 4, 0);
    $display("test wrap burst done");
  endtask : t_wrap
  task automatic t_slow();
    burst(base + 17, 3, 7);
    $display("test slow master done");
  endtask : t_slow
  task automatic t_miss();
    int s0;
    int h0;
    for (int j = 0; j < 2; j++) begin
      s0 = seen;
      h0 = m_u.hung;
      m_u.run(j ? base + 256 : base - 1, 1, 0);
      `CHK("miss drive", s0, seen)
      `CHK("miss hang", h0 + 1, m_u.hung)
    end
    $display("test miss done");
  endtask : t_miss
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Clock of 8 ns period.
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Watchdog cuts a hang short.
  initial begin
    #200us;
    fails++;
    give_verdict();
  end
  // Reset, fill the memory, then run the scenarios.
  initial begin
    sys_rst = 1'b1;
    {fill_en, fill_addr, fill_data} = 41'h0;
    {fails, samples_checked} = 0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 0;
    for (int i = 0; i < 256; i++) begin
      @(posedge sys_clk);
      fill_en <= 1;
      fill_addr <= i[7:0];
      fill_data <= fv(i);
    end
    @(posedge sys_clk);
    fill_en <= 0;
    t_first();
    t_wrap();
    t_slow();
    t_miss();
    give_verdict();
  end
endmodule : dma_handshake_read_target_tb
